// *** chain_pkg.sv ***
// Operation
// - Data flows first device to last device.
// - Write executes on chip select rising edge.
// - No read result during request frame.
// - Even output bytes carry read data.
// - Odd output bytes echo instruction and address.
// - Output feeds next input; select, clock shared.
package chain_pkg;
    localparam int          WORD_W      = 16;
    localparam int          BYTE_W      = 8;
    localparam int          CNT_W       = 5;
    localparam int          FIFO_DEPTH  = 8;
    localparam int          REG_AW      = 5;
    localparam int          NUM_REGS    = 32;
    localparam logic [1:0]  OP_READ     = 2'h0;
    localparam logic [1:0]  OP_WRITE    = 2'h2;
    localparam logic [4:0]  BITS_PER_CMD = 5'h10;
    localparam logic [7:0]  REG_RESET   = 8'h80;
endpackage : chain_pkg

// *** cmd_fifo.sv ***
module cmd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= AW'((wr_ptr_r + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_r <= AW'((rd_ptr_r + 1'b1) % DEPTH);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cmd_fifo

// *** chained_pot_device.sv ***
module chained_pot_device
    import chain_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe_n,
    output logic [7:0]       wiper,
    output logic             cmd_drop
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        APPLY_IDLE = 1'b0,
        APPLY_RUN  = 1'b1
    } apply_t;

    typedef struct packed {
        logic [2:0]        cs_s;
        logic [2:0]        ck_s;
        logic [2:0]        di_s;
        logic              cs_q;
        logic              ck_q;
        logic [WORD_W-1:0] shift;
        logic [CNT_W-1:0]  bits;
        logic              out_bit;
        logic              oe_n;
        logic              pend_rd;
        logic [REG_AW-1:0] pend_addr;
        logic [1:0]        pend_op;
        logic [7:0]        wiper;
        logic              drop;
        apply_t            ast;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [7:0]        regs_r [NUM_REGS];
    logic [WORD_W-1:0] fifo_out;
    logic              fifo_ovalid;
    logic              fifo_iready;
    logic              fifo_push;
    logic              fifo_pop;
    logic              cs_rise;
    logic              cs_fall;
    logic              ck_rise;
    logic              ck_fall;
    logic              cs_lvl;
    logic              ck_lvl;
    logic              di_lvl;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    // A select or clock change counts once the second and third stages agree
    assign cs_lvl  = (st_r.cs_s[1] == st_r.cs_s[2]) ? st_r.cs_s[2] : st_r.cs_q;
    assign ck_lvl  = (st_r.ck_s[1] == st_r.ck_s[2]) ? st_r.ck_s[2] : st_r.ck_q;
    assign di_lvl  = st_r.di_s[2];
    assign cs_rise = cs_lvl && !st_r.cs_q;
    assign cs_fall = !cs_lvl && st_r.cs_q;
    assign ck_rise = ck_lvl && !st_r.ck_q && !cs_lvl;
    assign ck_fall = !ck_lvl && st_r.ck_q && !cs_lvl;

    // ------------------------------------------------------------
    // Command queue
    // ------------------------------------------------------------
    // The queue decouples frame end from applying the command
    assign fifo_push = cs_rise && (st_r.bits >= BITS_PER_CMD);

    cmd_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_data   (st_r.shift),
        .in_valid  (fifo_push),
        .in_ready  (fifo_iready),
        .out_data  (fifo_out),
        .out_valid (fifo_ovalid),
        .out_ready (fifo_pop)
    );

    // Applying stalls while a frame is open, so the queue can fill
    assign fifo_pop = fifo_ovalid && cs_lvl && (st_r.ast == APPLY_RUN);

    always_ff @(posedge ref_clk) begin
        if (fifo_pop && fifo_out[15:14] == OP_WRITE) begin
            regs_r[fifo_out[12:8]] <= fifo_out[7:0];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.cs_s = {st_r.cs_s[1:0], cs_n};
        st_nxt.ck_s = {st_r.ck_s[1:0], sclk};
        st_nxt.di_s = {st_r.di_s[1:0], sdi};
        st_nxt.cs_q = cs_lvl;
        st_nxt.ck_q = ck_lvl;
        st_nxt.oe_n = cs_lvl;

        if (cs_fall) begin
            st_nxt.bits = '0;
            if (st_r.pend_rd) begin
                st_nxt.shift   = {st_r.pend_op, 1'b0, st_r.pend_addr,
                                  regs_r[st_r.pend_addr]};
                st_nxt.pend_rd = 1'b0;
                st_nxt.out_bit = st_r.pend_op[1];
            end else begin
                st_nxt.shift   = '0;
                st_nxt.out_bit = 1'b0;
            end
        end

        if (ck_rise) begin
            st_nxt.shift = {st_r.shift[WORD_W-2:0], di_lvl};
            if (st_r.bits != '1) begin
                st_nxt.bits = st_r.bits + 1'b1;
            end
        end

        if (ck_fall) begin
            st_nxt.out_bit = st_r.shift[WORD_W-1];
        end

        st_nxt.drop = fifo_push && !fifo_iready;

        if (cs_rise && st_r.bits >= BITS_PER_CMD
                && st_r.shift[15:14] == OP_READ) begin
            st_nxt.pend_rd   = 1'b1;
            st_nxt.pend_addr = st_r.shift[12:8];
            st_nxt.pend_op   = st_r.shift[15:14];
        end

        unique case (st_r.ast)
            APPLY_IDLE: begin
                if (fifo_ovalid) begin
                    st_nxt.ast = APPLY_RUN;
                end
            end
            APPLY_RUN: begin
                if (fifo_pop) begin
                    st_nxt.ast = APPLY_IDLE;
                    if (fifo_out[15:14] == OP_WRITE
                            && fifo_out[12:8] == '0) begin
                        st_nxt.wiper = fifo_out[7:0];
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{cs_s: 3'h7, ck_s: 3'h0, di_s: 3'h0, cs_q: 1'b1,
                      ck_q: 1'b0, shift: '0, bits: '0, out_bit: 1'b0,
                      oe_n: 1'b1, pend_rd: 1'b0, pend_addr: '0,
                      pend_op: 2'h0, wiper: REG_RESET, drop: 1'b0,
                      ast: APPLY_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sdo      = st_r.out_bit;
    assign sdo_oe_n = st_r.oe_n;
    assign wiper    = st_r.wiper;
    assign cmd_drop = st_r.drop;
endmodule : chained_pot_device

// *** chain_properties.sv ***
module chain_props (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       sdo,
    input  wire logic       sdo_oe_n,
    input  wire logic [7:0] wiper,
    input  wire logic       cmd_drop
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    oe_on_a: assert property ($fell(cs_n) |-> ##[2:6] !sdo_oe_n)
        else $error("output not enabled after select");
    oe_off_a: assert property ($rose(cs_n) |-> ##[2:6] sdo_oe_n)
        else $error("output not released after deselect");
    wiper_hold_a: assert property ($changed(wiper) |-> cs_n)
        else $error("wiper moved inside a frame");
    sdo_quiet_a: assert property
        ($rose(sclk) && !cs_n |=> $stable(sdo) [*3])
        else $error("serial out moved after clock rise");
    drop_idle_a: assert property (cmd_drop |-> cs_n)
        else $error("command lost inside a frame");
    idle_off_a: assert property (cs_n [*8] |-> sdo_oe_n)
        else $error("output driven while idle");
    oe_rise_a: assert property ($rose(sdo_oe_n) |-> cs_n)
        else $error("output released while selected");
    oe_fall_a: assert property ($fell(sdo_oe_n) |-> !cs_n)
        else $error("output enabled while deselected");
    cover property ($changed(wiper));
    cover property ($fell(sdo_oe_n));
    cover property ($rose(sclk) && !cs_n);
endmodule // chain_props

bind chained_pot_device chain_props chain_props_i (
    .ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .wiper(wiper), .cmd_drop(cmd_drop));

// *** spi_host_model.sv ***
module spi_host_model (
    input  wire logic ref_clk,
    input  wire logic miso,
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b1;
    end
    // whole frames, shared clock, last word first
    task automatic frame(input logic [31:0] w, input int n,
                         output logic [31:0] r);
        r = '0;
        @(negedge ref_clk) cs_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        for (int i = n - 1; i >= 0; i--) begin
            mosi = w[i];
            repeat (4) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            r[i] = miso;
            sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        // Released data line shows the inverse so no stale bit passes
        mosi = ~mosi;
        cs_n = 1'b1;
        repeat (12) @(negedge ref_clk);
    endtask
endmodule // spi_host_model

// *** daisy_chain_spi_pot_access_tb.sv ***
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module daisy_chain_spi_pot_access_tb;
    import chain_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, nrst, cs_n, sclk, mosi, s0, s1, oe0, oe1, d0, d1;
    logic        l0, l1;
    logic [7:0]  w0, w1;
    logic [31:0] r;
    logic        drop_seen;
    int          err_count = 0;
    int          checks_done = 0;
    // Pull-ups on the link between devices and on the link to the host
    assign l0 = oe0 ? 1'b1 : s0;
    assign l1 = oe1 ? 1'b1 : s1;
    chained_pot_device chained_pot_device_i (.ref_clk(ref_clk), .nrst(nrst),
        .cs_n(cs_n), .sclk(sclk), .sdi(mosi), .sdo(s0), .sdo_oe_n(oe0),
        .wiper(w0), .cmd_drop(d0));
    chained_pot_device tail_chained_pot_device_i (.ref_clk(ref_clk),
        .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .sdi(l0), .sdo(s1),
        .sdo_oe_n(oe1), .wiper(w1), .cmd_drop(d1));
    spi_host_model spi_host_model_i (.ref_clk(ref_clk), .miso(l1),
        .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Sticky record of any lost command pulse from either device
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) drop_seen <= 1'b0;
        else if (d0 || d1) drop_seen <= 1'b1;
    end
    task automatic results;
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_write;
        `CHK("wiper0 reset", REG_RESET, w0)
        `CHK("wiper1 reset", REG_RESET, w1)
        spi_host_model_i.frame(32'h803c_80c5, 32, r);
        `CHK("wiper0", 8'hc5, w0)
        `CHK("wiper1", 8'h3c, w1)
        spi_host_model_i.frame(32'h87a7_835a, 32, r);
    endtask
    task automatic t_read;
        spi_host_model_i.frame(32'h0700_0300, 32, r);
        `CHK("request out", 32'h0000_0000, r)
        spi_host_model_i.frame(32'h0000_0000, 32, r);
        `CHK("collect", 32'h07a7_035a, r)
        `CHK("wiper1 kept", 8'h3c, w1)
    endtask
    // Twelve-bit frame must leave every device untouched
    task automatic t_short;
        spi_host_model_i.frame(32'h0000_0811, 12, r);
        `CHK("wiper0 kept", 8'hc5, w0)
        `CHK("wiper1 kept", 8'h3c, w1)
        `CHK("no drop", 1'b0, drop_seen)
    endtask
    initial begin
        nrst = 1'b0;
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_write();
        t_read();
        t_short();
        results();
    end
    initial begin
        #300000;
        err_count++;
        results();
    end
endmodule // daisy_chain_spi_pot_access_tb
